// ===== design/instr_class_if.sv
// Purpose: Carries a decode-stage word to the classifier and its verdict back.
// Assumes: Purely combinational path inside one clock domain.
// Notes:   None.
`timescale 1ns/1ps
`default_nettype none
interface instr_class_if;
   import undef_abort_pkg::*;
   logic [WORD_W-1:0] instr;
   logic undef_fixed;
   logic needs_priv;
   logic pc_store;
   logic base_wb;
   logic [3:0] base_reg;

   modport classifier (
      input instr,
      output undef_fixed,
      output needs_priv,
      output pc_store,
      output base_wb,
      output base_reg
   );
   modport pipe (
      output instr,
      input undef_fixed,
      input needs_priv,
      input pc_store,
      input base_wb,
      input base_reg
   );
endinterface
`default_nettype wire

// ===== design/instr_classifier.sv
// Purpose: Sorts one instruction word into undefined spaces, privileged
//          coprocessor transfers, program-counter stores and base writeback.
// Assumes: Word is a 32-bit instruction; condition is judged elsewhere.
// Notes:   Combinational only.
`timescale 1ns/1ps
`default_nettype none
module instr_classifier
   import undef_abort_pkg::*;
(
   instr_class_if.classifier cls
);

   logic [WORD_W-1:0] i;
   logic undef_space, arith_undef, ctrl_space, ctrl_def, ls_space, ls_def, swap;
   logic cp_ext, system_control_coprocessor, cp_mem, cp_data, cp_reg, single, multi;

   always_comb begin
      i = cls.instr;
      undef_space = (i[27:25] == UNDEF_SPACE_OP) && i[4];
      arith_undef = (i[27:24] == 4'h0) && (i[7:4] == 4'h9) && (i[23:22] == 2'h1);
      ctrl_space = (i[27:26] == 2'h0) && (i[24:23] == 2'h2) && !i[20]
                   && !(!i[25] && i[7] && i[4]);
      ctrl_def = (!i[25] && (i[11:4] == 8'h00)) || (i[25] && i[21])
                 || (i[27:4] == 24'h12fff1);
      ls_space = (i[27:25] == 3'h0) && i[7] && i[4] && !((i[6:5] == 2'h0) && !i[24]);
      swap = (i[6:5] == 2'h0) && !i[23] && (i[21:20] == 2'h0) && (i[11:8] == 4'h0);
      ls_def = (i[6:5] == 2'h1) || (i[6] && i[LOAD_BIT]) || swap;
      cp_ext = (i[27:23] == 5'h18) && !i[21];
      system_control_coprocessor = (i[CP_NUM_LSB +: 4] == SYS_CTRL_CP_NUM);
      cp_mem = (i[27:25] == 3'h6) && !cp_ext;
      cp_data = (i[27:24] == 4'he) && !i[4];
      cp_reg = (i[27:24] == 4'he) && i[4];
      single = (i[27:26] == 2'h1) && !undef_space;
      multi = (i[27:25] == 3'h4);

      cls.undef_fixed = undef_space || arith_undef || (ctrl_space && !ctrl_def)
                        || (ls_space && !ls_def) || cp_ext
                        || (system_control_coprocessor && (cp_data || cp_mem));
      cls.needs_priv = system_control_coprocessor && cp_reg;
      cls.pc_store = (single && !i[LOAD_BIT] && (i[RD_LSB +: 4] == PC_REG))
                     || (multi && !i[LOAD_BIT] && i[PC_LIST_BIT]);
      cls.base_wb = (single && (!i[PRE_BIT] || i[WB_BIT]))
                    || (multi && i[WB_BIT])
                    || (ls_space && ls_def && !swap && (!i[PRE_BIT] || i[WB_BIT]))
                    || (cp_mem && i[WB_BIT]);
      cls.base_reg = i[BASE_LSB +: 4];
   end

endmodule // instr_classifier
`default_nettype wire

// ===== design/undef_abort_pkg.sv
// Purpose: Shared constants and stage records for the undefined-instruction
//          and abort-restore block.
// Assumes: 32-bit instruction words, core clock only.
// Notes:   Field positions name the low bit of each instruction field.
package undef_abort_pkg;

   localparam int unsigned WORD_W = 32;

   // ****************************************************************
   // Instruction field positions
   // ****************************************************************
   localparam int unsigned RD_LSB = 12;
   localparam int unsigned BASE_LSB = 16;
   localparam int unsigned CP_NUM_LSB = 8;
   localparam int unsigned LOAD_BIT = 20;
   localparam int unsigned WB_BIT = 21;
   localparam int unsigned PRE_BIT = 24;
   localparam int unsigned PC_LIST_BIT = 15;

   // ****************************************************************
   // Encodings and values
   // ****************************************************************
   localparam logic [2:0] UNDEF_SPACE_OP = 3'h3;
   localparam logic [3:0] SYS_CTRL_CP_NUM = 4'hf;
   localparam logic [3:0] PC_REG = 4'hf;
   localparam logic [WORD_W-1:0] PC_STORE_OFFSET = 32'h0000000c;

   // ****************************************************************
   // Stage records
   // ****************************************************************
   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] instr;
      logic [WORD_W-1:0] addr;
   } front_s;

   typedef struct packed {
      logic valid;
      logic undef_fixed;
      logic needs_priv;
      logic pc_store;
      logic base_wb;
      logic [3:0] base_reg;
      logic [WORD_W-1:0] addr;
   } exec_s;

   typedef struct packed {
      logic valid;
      logic base_wb;
      logic [3:0] base_reg;
      logic [WORD_W-1:0] base_value;
      logic [WORD_W-1:0] addr;
   } mem_s;

endpackage

// ===== design/undef_decode_abort_restore.sv
// Purpose: Tracks instructions through a five-stage pipeline, raises the
//          undefined-instruction exception, restores the base register on a
//          data abort and supplies the value stored for a program counter.
// Assumes: Core supplies condition result, mode and base value at execute.
// Notes:   Summary of operation below.
// Summary of operation
// - Instructions move in order through fetch, decode, execute, memory, write-back.
// - Bits 27..25 equal 011 with bit 4 set is undefined.
// - Unused encodings in the arithmetic, control and load/store extension spaces, and the whole coprocessor extension space, are undefined.
// - Data abort in memory access restores base register's prior value.
// - Storing the program counter directly stores instruction address plus 12.
// - System coprocessor data/load/store ops trap; unprivileged transfers trap.
`timescale 1ns/1ps
`default_nettype none
module undef_decode_abort_restore
   import undef_abort_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic fetch_valid_i,
   input wire logic [WORD_W-1:0] fetch_instr_i,
   input wire logic [WORD_W-1:0] fetch_addr_i,
   input wire logic stall_i,
   input wire logic flush_i,
   input wire logic cond_pass_i,
   input wire logic privileged_i,
   input wire logic [WORD_W-1:0] base_value_i,
   input wire logic data_abort_i,
   output logic exec_valid_o,
   output logic [3:0] exec_base_reg_o,
   output logic undef_o,
   output logic [WORD_W-1:0] undef_addr_o,
   output logic restore_o,
   output logic [3:0] restore_reg_o,
   output logic [WORD_W-1:0] restore_value_o,
   output logic pc_store_o,
   output logic [WORD_W-1:0] pc_store_value_o,
   output logic retire_o,
   output logic [WORD_W-1:0] retire_addr_o
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Data outputs other than exec_base_reg_o keep their last value between pulses of their group
   function automatic logic [WORD_W-1:0] take_word(input logic load,
                                                  input logic [WORD_W-1:0] fresh,
                                                  input logic [WORD_W-1:0] held);
      take_word = load ? fresh : held;
   endfunction

   function automatic logic [3:0] take_index(input logic load,
                                             input logic [3:0] fresh,
                                             input logic [3:0] held);
      take_index = load ? fresh : held;
   endfunction

   // Value written out when the program counter itself is stored
   function automatic logic [WORD_W-1:0] stored_pc(input logic [WORD_W-1:0] instr_addr);
      stored_pc = WORD_W'(instr_addr + PC_STORE_OFFSET);
   endfunction

   // ****************************************************************
   // Pipeline stages
   // ****************************************************************
   front_s fe, de, next_fe, next_de;
   exec_s ex, next_ex;
   mem_s me, next_me;
   logic fire, undef_hit, abort_hit;

   instr_class_if cls_if ();

   instr_classifier u_classifier (
      .cls(cls_if.classifier)
   );

   // Classifier judges the word held in decode
   assign cls_if.instr = de.instr;

   // ****************************************************************
   // Execute judgement
   // ****************************************************************
   always_comb begin
      fire = ex.valid && !stall_i && !flush_i && cond_pass_i;
      undef_hit = fire && (ex.undef_fixed || (ex.needs_priv && !privileged_i));
      abort_hit = me.valid && data_abort_i;
   end

   // ****************************************************************
   // Fetch and decode
   // ****************************************************************
   always_comb begin
      next_fe = fe;
      next_de = de;
      if (!stall_i) begin
         next_fe.valid = fetch_valid_i;
         next_fe.instr = fetch_instr_i;
         next_fe.addr = fetch_addr_i;
         next_de = fe;
      end
      // Flush wins over stall
      if (flush_i) begin
         next_fe.valid = 1'b0;
         next_de.valid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         fe <= '0;
         de <= '0;
      end else begin
         fe <= next_fe;
         de <= next_de;
      end
   end

   // ****************************************************************
   // Execute
   // ****************************************************************
   always_comb begin
      next_ex = ex;
      // decode verdict travels with its word
      // Stalled word stays and is judged again
      if (!stall_i) begin
         next_ex.valid = de.valid;
         next_ex.undef_fixed = cls_if.undef_fixed;
         next_ex.needs_priv = cls_if.needs_priv;
         next_ex.pc_store = cls_if.pc_store;
         next_ex.base_wb = cls_if.base_wb;
         next_ex.base_reg = cls_if.base_reg;
         next_ex.addr = de.addr;
      end
      // Memory and write-back are already committed; only younger stages die
      if (flush_i) begin
         next_ex.valid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ex <= '0;
      end else begin
         ex <= next_ex;
      end
   end

   // ****************************************************************
   // Memory access
   // ****************************************************************
   always_comb begin
      next_me = '0;
      // A trapped or flushed instruction never reaches memory; a stalled one waits in execute
      next_me.valid = fire && !undef_hit;
      next_me.base_wb = ex.base_wb;
      next_me.base_reg = ex.base_reg;
      next_me.base_value = base_value_i;
      next_me.addr = ex.addr;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         me <= '0;
      end else begin
         me <= next_me;
      end
   end

   // ****************************************************************
   // Output registers
   // ****************************************************************
   logic next_undef, next_restore, next_pc_store, next_retire;
   logic [WORD_W-1:0] next_undef_addr, next_restore_value, next_pc_store_value;
   logic [WORD_W-1:0] next_retire_addr;
   logic [3:0] next_restore_reg;

   always_comb begin
      next_undef = undef_hit;
      next_undef_addr = take_word(undef_hit, ex.addr, undef_addr_o);
      next_restore = abort_hit && me.base_wb;
      next_restore_reg = take_index(next_restore, me.base_reg, restore_reg_o);
      next_restore_value = take_word(next_restore, me.base_value, restore_value_o);
      next_pc_store = next_me.valid && ex.pc_store;
      next_pc_store_value = take_word(next_pc_store, stored_pc(ex.addr), pc_store_value_o);
      // Aborted instructions do not retire
      next_retire = me.valid && !data_abort_i;
      next_retire_addr = take_word(next_retire, me.addr, retire_addr_o);
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         exec_valid_o <= 1'b0;
         exec_base_reg_o <= 4'h0;
         undef_o <= 1'b0;
         undef_addr_o <= '0;
         restore_o <= 1'b0;
         restore_reg_o <= 4'h0;
         restore_value_o <= '0;
         pc_store_o <= 1'b0;
         pc_store_value_o <= '0;
         retire_o <= 1'b0;
         retire_addr_o <= '0;
      end else begin
         exec_valid_o <= next_ex.valid;
         exec_base_reg_o <= next_ex.base_reg;
         undef_o <= next_undef;
         undef_addr_o <= next_undef_addr;
         restore_o <= next_restore;
         restore_reg_o <= next_restore_reg;
         restore_value_o <= next_restore_value;
         pc_store_o <= next_pc_store;
         pc_store_value_o <= next_pc_store_value;
         retire_o <= next_retire;
         retire_addr_o <= next_retire_addr;
      end
   end

endmodule // undef_decode_abort_restore
`default_nettype wire

// ===== tb/base_reg_model.sv
// Purpose: Core register file as seen by the block at execute.
// Assumes: Base value is read in the same cycle as the index.
// Notes: Each register reads back a distinct value.
`timescale 1ns/1ps
`default_nettype none
module base_reg_model
   import undef_abort_pkg::*;
(
   input wire logic [3:0] base_reg_i,
   output logic [WORD_W-1:0] base_value_o
);
   // Distinct per index, so a wrong index shows up in the restore
   assign base_value_o = 32'h40000000 | {20'h0, base_reg_i, 8'h5a};
endmodule // base_reg_model
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the trap and abort-restore block.
// Assumes: One word in flight at a time; inputs change at falling edge.
// Notes: Table words cover the extension spaces; random words the 011 space.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import undef_abort_pkg::*;
;
   logic sys_clk_i, reset_i, fetch_valid_i, stall_i, flush_i, cond_pass_i, privileged_i;
   logic data_abort_i, exec_valid_o, undef_o, restore_o, pc_store_o, retire_o;
   logic [3:0] exec_base_reg_o, restore_reg_o;
   logic [WORD_W-1:0] fetch_instr_i, fetch_addr_i, base_value_i, undef_addr_o;
   logic [WORD_W-1:0] restore_value_o, pc_store_value_o, retire_addr_o, w;
   logic [36:0] tbl [14];
   integer seed = 32'hdfad;
   integer r;
   int err_total = 0;
   int cmp_count = 0;
   undef_decode_abort_restore uut (.sys_clk_i, .reset_i, .fetch_valid_i, .fetch_instr_i,
      .fetch_addr_i, .stall_i, .flush_i, .cond_pass_i, .privileged_i, .base_value_i,
      .data_abort_i, .exec_valid_o, .exec_base_reg_o, .undef_o, .undef_addr_o, .restore_o,
      .restore_reg_o, .restore_value_o, .pc_store_o, .pc_store_value_o, .retire_o,
      .retire_addr_o);
   base_reg_model peer (.base_reg_i(exec_base_reg_o), .base_value_o(base_value_i));
   initial begin
      sys_clk_i = 0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string n, input logic [31:0] e, s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic close_out;
      $display("Compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Bit 1: stores the pc; bit 0: writes the base back
   function automatic logic [1:0] mem_kind(input logic [31:0] v);
      mem_kind[1] = !v[20] && ((v[27:26] == 2'b01 && v[15:12] == PC_REG) ||
         (v[27:25] == 3'b100 && v[15]));
      mem_kind[0] = (v[27:26] == 2'b01 && (!v[24] || v[21])) || (v[27:25] == 3'b100 && v[21]);
   endfunction
   // Mode: 0 plain, 1 condition fails, 2 abort, 3 stall, 4 flush
   task automatic run(input logic [31:0] v, input logic pv, eu, input int m);
      logic [31:0] a;
      logic [1:0] k;
      logic live, p;
      a = $random(seed);
      a[1:0] = 2'h0;
      k = mem_kind(v);
      live = m != 1 && m != 4;
      p = live && !eu;
      fetch_valid_i = 1;
      fetch_instr_i = v;
      fetch_addr_i = a;
      privileged_i = pv;
      cond_pass_i = m != 1;
      @(negedge sys_clk_i);
      fetch_valid_i = 0;
      // One cycle in the fetch register, one in decode
      @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      chk("exec_valid", 1, exec_valid_o);
      chk("base_reg", v[19:16], exec_base_reg_o);
      stall_i = m == 3;
      flush_i = m == 4;
      if (m == 3) begin
         @(negedge sys_clk_i);
         stall_i = 0;
      end
      @(negedge sys_clk_i);
      flush_i = 0;
      data_abort_i = m == 2;
      chk("undef", eu && live, undef_o);
      if (eu && live) chk("undef_addr", a, undef_addr_o);
      chk("pc_store", p && k[1], pc_store_o);
      if (p && k[1]) chk("pc_value", a + 32'hc, pc_store_value_o);
      @(negedge sys_clk_i);
      data_abort_i = 0;
      chk("restore", p && k[0] && m == 2, restore_o);
      if (p && k[0] && m == 2) begin
         chk("rest_val", 32'h40000000 | {v[19:16], 8'h5a}, restore_value_o);
         chk("rest_reg", v[19:16], restore_reg_o);
      end
      chk("retire", p && m != 2, retire_o);
      if (p && m != 2) chk("retire_addr", a, retire_addr_o);
   endtask
   initial begin
      // Entries: privileged, undefined, mode, word
      tbl = '{{5'h18, 32'he0400090}, {5'h18, 32'he1000050}, {5'h18, 32'he1c000d0},
         {5'h18, 32'hec000100}, {5'h18, 32'hee000f00}, {5'h18, 32'hed800f00},
         {5'h08, 32'hee000f10}, {5'h10, 32'hee000f10}, {5'h10, 32'he58ff000},
         {5'h12, 32'he4a1f004}, {5'h12, 32'he92d8000}, {5'h11, 32'he1a00000},
         {5'h1b, 32'he7f000f0}, {5'h1c, 32'he7f000f0}};
      {fetch_valid_i, stall_i, flush_i, cond_pass_i, privileged_i, data_abort_i} = 6'h0;
      fetch_instr_i = 32'h0;
      fetch_addr_i = 32'h0;
      reset_i = 1;
      repeat (10) @(negedge sys_clk_i);
      chk("undef_rst", 0, undef_o);
      reset_i = 0;
      foreach (tbl[i]) run(tbl[i][31:0], tbl[i][36], tbl[i][35], int'(tbl[i][34:32]));
      reset_i = 1;
      @(negedge sys_clk_i);
      reset_i = 0;
      repeat (40) begin
         r = $random(seed);
         w = $random(seed);
         w[31:25] = 7'h73;
         run(w, r[0], w[4], int'(r[2:1]) + r[3]);
      end
      close_out();
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      close_out();
   end
endmodule // tb_top
`default_nettype wire

// ===== tb/undef_abort_chk.sv
// Purpose: Concurrent checks on trap, store value and base restore.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to undef_decode_abort_restore.
`timescale 1ns/1ps
`default_nettype none
module undef_abort_chk
   import undef_abort_pkg::*;
(
   input wire logic sys_clk_i, reset_i, fetch_valid_i, stall_i, flush_i, cond_pass_i,
   input wire logic data_abort_i, exec_valid_o, undef_o, restore_o, pc_store_o, retire_o,
   input wire logic [3:0] exec_base_reg_o, restore_reg_o,
   input wire logic [WORD_W-1:0] fetch_instr_i, fetch_addr_i, base_value_i, undef_addr_o,
   input wire logic [WORD_W-1:0] restore_value_o, pc_store_value_o, retire_addr_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic go;
   logic judge;
   assign go = fetch_valid_i && !stall_i && !flush_i;
   assign judge = exec_valid_o && cond_pass_i && !stall_i && !flush_i;
   a_exec_after_take: assert property (go ##1 (!stall_i && !flush_i) ##1
      (!stall_i && !flush_i) |=> exec_valid_o)
      else $error("word did not reach execute");
   a_undef_space_trap: assert property (go && fetch_instr_i[27:25] == UNDEF_SPACE_OP &&
      fetch_instr_i[4] ##1 (!stall_i && !flush_i) ##1 (!stall_i && !flush_i) ##1
      (!stall_i && !flush_i && cond_pass_i)
      |=> undef_o && undef_addr_o == $past(fetch_addr_i, 4)) else $error("undefined word missed");
   a_undef_cause: assert property (undef_o |-> $past(judge))
      else $error("trap without judged word");
   a_flush_quiet: assert property (flush_i |=> !undef_o && !pc_store_o)
      else $error("flushed word had effect");
   a_cond_fail_quiet: assert property (exec_valid_o && !cond_pass_i |=> !undef_o)
      else $error("failed condition trapped");
   a_pc_store_sum: assert property (pc_store_o && !data_abort_i |=> retire_o &&
      retire_addr_o + PC_STORE_OFFSET == $past(pc_store_value_o))
      else $error("stored pc value wrong");
   a_restore_cause: assert property (restore_o |-> $past(data_abort_i) && !retire_o)
      else $error("restore without abort");
   a_restore_value: assert property (restore_o |-> restore_value_o == $past(base_value_i, 2)
      && restore_reg_o == $past(exec_base_reg_o, 2)) else $error("restored base wrong");
endmodule // undef_abort_chk
bind undef_decode_abort_restore undef_abort_chk u_chk (.sys_clk_i, .reset_i, .fetch_valid_i,
   .stall_i, .flush_i, .cond_pass_i, .data_abort_i, .exec_valid_o, .undef_o, .restore_o,
   .pc_store_o, .retire_o, .exec_base_reg_o, .restore_reg_o, .fetch_instr_i, .fetch_addr_i,
   .base_value_i, .undef_addr_o, .restore_value_o, .pc_store_value_o, .retire_addr_o);
`default_nettype wire
